/* hdl/synth_dual_modulus_divider.sv */
/*
 * Pulse-swallowing programmable divider with reference path and lock flag.
 * Assumes the oscillator and reference inputs toggle slower than half the
 * 25 MHz sampling clock; selection switches are asynchronous levels.
 */
`timescale 1ns/1ps
`default_nettype none
module synth_dual_modulus_divider (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  osc_in,
    input  wire logic                  ref_in,
    input  wire divider_pkg::freq_sel_t freq_sel,
    output logic                       div_pulse,
    output logic                       ref_pulse,
    output logic                       unlock
);
    import divider_pkg::*;

    div_state_t st_r;
    div_state_t st_nxt;
    logic       osc_edge;
    logic       pre_wrap;
    logic       low_term;
    logic [6:0] chan_clamped;
    logic [8:0] low_load;
    logic       ref_tick;

    // ------------------------------------------------------------------
    // Reference path
    // ------------------------------------------------------------------
    ref_divider i_ref_divider (
        .clock     (clock),
        .reset     (reset),
        .ref_in    (ref_in),
        .ref_pulse (ref_tick)
    );

    assign ref_pulse = ref_tick;
    assign div_pulse = st_r.div_pulse;
    assign unlock    = st_r.unlock;

    // ------------------------------------------------------------------
    // Ratio decode
    // ------------------------------------------------------------------
    // Out-of-range channel codes clamp so the count never leaves the band.
    assign chan_clamped = (st_r.sel_s2.chan > CHAN_MAX) ? CHAN_MAX
                                                        : st_r.sel_s2.chan;

    assign low_load = (st_r.sel_s2.rx_mode ? RX_LOW_MIN : TX_LOW_MIN)
                    + {2'b00, chan_clamped};

    assign osc_edge = st_r.osc_sync[1] & ~st_r.osc_prev;

    assign pre_wrap = osc_edge
                    && (st_r.pre_cnt == ((st_r.swal_left != 2'h0)
                        ? PRESCALE_SWAL - 3'h1 : PRESCALE_BASE - 3'h1));

    assign low_term = pre_wrap && (st_r.low_cnt <= 9'h001);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.osc_sync  = {st_r.osc_sync[0], osc_in};
        st_nxt.osc_prev  = st_r.osc_sync[1];
        st_nxt.sel_s1    = freq_sel;
        st_nxt.sel_s2    = st_r.sel_s1;
        st_nxt.div_pulse = 1'b0;

        if (osc_edge) begin
            st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
        end
        if (pre_wrap) begin
            st_nxt.pre_cnt = PRE_CNT_RESET;
            if (st_r.swal_left != 2'h0) begin
                st_nxt.swal_left = st_r.swal_left - 2'h1;
            end
            st_nxt.low_cnt = st_r.low_cnt - 9'h001;
        end
        // Period ends; reload count and swallows.
        if (low_term) begin
            st_nxt.low_cnt   = low_load;
            st_nxt.swal_left = st_r.sel_s2.step;
            st_nxt.div_pulse = 1'b1;
        end

        // One divided pulse per reference period means a match.
        // A divided pulse that meets the reference tick opens the window.
        if (ref_tick) begin
            st_nxt.unlock  = (st_r.win_cnt != 2'h1);
            st_nxt.win_cnt = {1'b0, st_r.div_pulse};
        end else if (st_r.div_pulse && st_r.win_cnt != 2'h3) begin
            st_nxt.win_cnt = st_r.win_cnt + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            // Low count starts at one so the first prescaler cycle ends a
            // period and loads the selected count.
            st_r         <= '0;
            st_r.low_cnt <= LOW_CNT_RESET;
            st_r.unlock  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Checks sample at the clock and stay masked during reset; after
    // release the synchronisers need three clocks before an edge counts.
    // Short phases on osc_in or ref_in are not flagged: they lose edges.
    sequence swallow_wrap_s;
        pre_wrap && st_r.swal_left != 2'h0 && !low_term;
    endsequence

    sequence last_swallow_s;
        pre_wrap && st_r.swal_left == 2'h1 && !low_term;
    endsequence

    sequence period_end_s;
        low_term ##1 st_r.div_pulse;
    endsequence

    pulse_single_a: assert property (
        @(posedge clock) disable iff (reset)
        st_r.div_pulse |=> !st_r.div_pulse)
        else $error("Divided pulse lasted more than one cycle.");

    pulse_source_a: assert property (
        @(posedge clock) disable iff (reset)
        st_r.div_pulse |-> $past(low_term))
        else $error("Divided pulse without a period end.");

    base_modulus_a: assert property (
        @(posedge clock) disable iff (reset)
        (osc_edge && st_r.swal_left == 2'h0
            && st_r.pre_cnt == PRESCALE_BASE - 3'h1)
            |=> st_r.pre_cnt == PRE_CNT_RESET)
        else $error("Prescaler did not wrap after four edges.");

    swal_modulus_a: assert property (
        @(posedge clock) disable iff (reset)
        (osc_edge && st_r.swal_left != 2'h0
            && st_r.pre_cnt == PRESCALE_BASE - 3'h1)
            |=> st_r.pre_cnt == PRESCALE_SWAL - 3'h1)
        else $error("Prescaler wrapped early while swallowing.");

    base_range_a: assert property (
        @(posedge clock) disable iff (reset)
        st_r.swal_left == 2'h0 |-> st_r.pre_cnt < PRESCALE_BASE)
        else $error("Prescaler passed four states without a swallow.");

    edge_only_a: assert property (
        @(posedge clock) disable iff (reset)
        !osc_edge |=> $stable(st_r.pre_cnt))
        else $error("Prescaler moved without an oscillator edge.");

    swallow_count_a: assert property (
        @(posedge clock) disable iff (reset)
        swallow_wrap_s |=> st_r.swal_left == $past(st_r.swal_left) - 2'h1)
        else $error("Swallow count did not step down.");

    swallow_end_a: assert property (
        @(posedge clock) disable iff (reset)
        last_swallow_s
            |=> st_r.swal_left == 2'h0 && st_r.pre_cnt == PRE_CNT_RESET)
        else $error("Prescaler did not return to four after swallows.");

    tx_band_a: assert property (
        @(posedge clock) disable iff (reset)
        (low_term && !st_r.sel_s2.rx_mode)
            |=> (st_r.low_cnt >= TX_LOW_MIN && st_r.low_cnt <= TX_LOW_MAX))
        else $error("Transmit count outside 200 to 299.");

    rx_band_a: assert property (
        @(posedge clock) disable iff (reset)
        (low_term && st_r.sel_s2.rx_mode)
            |=> (st_r.low_cnt >= RX_LOW_MIN
                && st_r.low_cnt <= RX_LOW_MIN + {2'h0, CHAN_MAX}))
        else $error("Receive count outside shifted band.");

    period_pulse_a: assert property (
        @(posedge clock) disable iff (reset)
        period_end_s |-> st_r.swal_left == $past(st_r.sel_s2.step))
        else $error("Period end did not reload swallows.");

    ratio_reload_a: assert property (
        @(posedge clock) disable iff (reset)
        low_term |=> st_r.low_cnt == $past(low_load)
            && st_r.pre_cnt == PRE_CNT_RESET)
        else $error("Low-speed count not reloaded at period end.");

    low_step_a: assert property (
        @(posedge clock) disable iff (reset)
        (pre_wrap && !low_term)
            |=> st_r.low_cnt == $past(st_r.low_cnt) - 9'h001)
        else $error("Low-speed count did not step down.");

    low_hold_a: assert property (
        @(posedge clock) disable iff (reset)
        !pre_wrap |=> $stable(st_r.low_cnt))
        else $error("Low-speed count moved between prescaler cycles.");

    lock_flag_a: assert property (
        @(posedge clock) disable iff (reset)
        ref_tick |=> st_r.unlock == ($past(st_r.win_cnt) != 2'h1))
        else $error("Lock flag disagrees with pulse count.");

    unlock_hold_a: assert property (
        @(posedge clock) disable iff (reset)
        !ref_tick |=> $stable(st_r.unlock))
        else $error("Lock flag changed between reference ticks.");

    window_clear_a: assert property (
        @(posedge clock) disable iff (reset)
        (ref_tick && !st_r.div_pulse) |=> st_r.win_cnt == 2'h0)
        else $error("Pulse window not cleared at reference tick.");

endmodule // synth_dual_modulus_divider
`default_nettype wire

/* hdl/divider_pkg.sv */
/*
 * Constants and carrier types for the synthesizer dual-modulus divider.
 * Assumes one 25 MHz system clock that samples every input pin.
 */
// How it works
// - Divide oscillator by N, 25 kHz when locked.
// - Prescaler divides by four, five on swallow.
// - At most three divide-by-five cycles per period.
// - Transmit low-speed count spans 200 through 299.
// - Receive count shifted up for 23.0-32.9 MHz.
// - One output pulse per low-speed division cycle.
// - Reference square wave divided by exactly 100.
// - Lock indicator high unless the last reference period held one pulse.
package divider_pkg;

    // ------------------------------------------------------------------
    // Timing and ratio constants
    // ------------------------------------------------------------------
    localparam int          CLOCK_KHZ      = 25000;
    localparam int          COMPARE_KHZ    = 25;
    localparam int          REF_KHZ        = 2500;
    localparam logic [6:0]  REF_DIVISOR    = 7'(REF_KHZ / COMPARE_KHZ);
    localparam logic [2:0]  PRESCALE_BASE  = 3'h4;
    localparam logic [2:0]  PRESCALE_SWAL  = 3'h5;
    localparam logic [1:0]  SWALLOW_MAX    = 2'h3;
    localparam logic [8:0]  TX_LOW_MIN     = 9'h0c8;
    localparam logic [8:0]  TX_LOW_MAX     = 9'h12b;
    localparam logic [8:0]  RX_LOW_MIN     = 9'h0e6;
    localparam logic [6:0]  CHAN_MAX       = 7'h63;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [8:0]  LOW_CNT_RESET  = 9'h001;
    localparam logic [2:0]  PRE_CNT_RESET  = 3'h0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rx_mode;
        logic [6:0] chan;
        logic [1:0] step;
    } freq_sel_t;

    typedef struct packed {
        logic [1:0] ref_sync;
        logic       ref_prev;
        logic [6:0] ref_cnt;
        logic       ref_pulse;
    } ref_state_t;

    typedef struct packed {
        logic [1:0] osc_sync;
        logic       osc_prev;
        freq_sel_t  sel_s1;
        freq_sel_t  sel_s2;
        logic [2:0] pre_cnt;
        logic [1:0] swal_left;
        logic [8:0] low_cnt;
        logic       div_pulse;
        logic [1:0] win_cnt;
        logic       unlock;
    } div_state_t;

endpackage

/* hdl/ref_divider.sv */
/*
 * Reference path: divides the 2.5 MHz square wave to the comparison rate.
 * Assumes ref_in is asynchronous and slower than half the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ref_divider (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic ref_in,
    output logic      ref_pulse
);
    import divider_pkg::*;

    ref_state_t st_r;
    ref_state_t st_nxt;
    logic       ref_edge;

    assign ref_edge  = st_r.ref_sync[1] & ~st_r.ref_prev;
    assign ref_pulse = st_r.ref_pulse;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.ref_sync  = {st_r.ref_sync[0], ref_in};
        st_nxt.ref_prev  = st_r.ref_sync[1];
        st_nxt.ref_pulse = 1'b0;
        if (ref_edge) begin
            if (st_r.ref_cnt == REF_DIVISOR - 7'h01) begin
                st_nxt.ref_cnt   = 7'h00;
                st_nxt.ref_pulse = 1'b1;
            end else begin
                st_nxt.ref_cnt = st_r.ref_cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ref_wrap_a: assert property (@(posedge clock) disable iff (reset)
        (ref_edge && st_r.ref_cnt == REF_DIVISOR - 7'h01)
            |=> (st_r.ref_pulse && st_r.ref_cnt == 7'h00))
        else $error("Reference divider did not wrap at 100.");

endmodule // ref_divider
`default_nettype wire

/* testbench/osc_ref_model.sv */
/* Far-side model: slow oscillator and reference square waves.
   Assumes the bench picks half periods of at least two clocks. */
`timescale 1ns/1ps
`default_nettype none
module osc_ref_model (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [7:0] osc_half,
    input  wire logic [7:0] ref_half,
    output logic            osc_in,
    output logic            ref_in
);
    logic [7:0] osc_cnt_r;
    logic [7:0] ref_cnt_r;
    // Both waves toggle on whole clocks, so periods are exact multiples.
    always_ff @(posedge clock) begin
        if (reset) begin
            osc_cnt_r <= 8'h01;
            ref_cnt_r <= 8'h01;
            osc_in    <= 1'b0;
            ref_in    <= 1'b0;
        end else begin
            osc_cnt_r <= (osc_cnt_r >= osc_half) ? 8'h01 : osc_cnt_r + 8'h01;
            ref_cnt_r <= (ref_cnt_r >= ref_half) ? 8'h01 : ref_cnt_r + 8'h01;
            if (osc_cnt_r >= osc_half) osc_in <= ~osc_in;
            if (ref_cnt_r >= ref_half) ref_in <= ~ref_in;
        end
    end
endmodule // osc_ref_model
`default_nettype wire

/* testbench/tb_top.sv */
/* Self-checking bench for the dual-modulus divider.
   Assumes the far-side model drives slow oscillator and reference waves. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import divider_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] osc_half = 8'h02;
    logic [7:0] ref_half = 8'h02;
    freq_sel_t freq_sel = '0;
    logic osc_in, ref_in, div_pulse, ref_pulse, unlock;
    logic [15:0] div_gap, div_last, ref_gap, ref_last;
    logic [3:0] win;
    logic prev_div, prev_ref, chk, exp_unlock;
    int mismatches = 0;
    int compares = 0;

    initial forever #20 clock = ~clock;

    osc_ref_model i_osc_ref_model (.clock(clock), .reset(reset),
        .osc_half(osc_half), .ref_half(ref_half),
        .osc_in(osc_in), .ref_in(ref_in));
    synth_dual_modulus_divider i_synth_dual_modulus_divider (.clock(clock),
        .reset(reset), .osc_in(osc_in), .ref_in(ref_in),
        .freq_sel(freq_sel), .div_pulse(div_pulse),
        .ref_pulse(ref_pulse), .unlock(unlock));

    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic close_out;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Monitors: pulse gaps, pulse widths and the expected lock flag
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            div_gap <= 16'h0000;
            ref_gap <= 16'h0000;
            win <= 4'h0;
            chk <= 1'b0;
            prev_div <= 1'b0;
            prev_ref <= 1'b0;
        end else begin
            div_gap <= (div_pulse === 1'b1) ? 16'h0001 : div_gap + 16'h0001;
            ref_gap <= (ref_pulse === 1'b1) ? 16'h0001 : ref_gap + 16'h0001;
            if (div_pulse === 1'b1) div_last <= div_gap;
            if (ref_pulse === 1'b1) ref_last <= ref_gap;
            prev_div <= div_pulse;
            prev_ref <= ref_pulse;
            check(!(div_pulse && prev_div), "div pulse wide");
            check(!(ref_pulse && prev_ref), "ref pulse wide");
            if (chk) check(unlock === exp_unlock, "lock flag wrong");
            chk <= (ref_pulse === 1'b1);
            if (ref_pulse === 1'b1) begin
                exp_unlock <= (win != 4'h1);
                win <= {3'h0, div_pulse};
            end else if (div_pulse === 1'b1 && win != 4'hf) begin
                win <= win + 4'h1;
            end
        end
    end

    task automatic wait_ev(input bit use_ref, input int n);
        int cnt;
        for (int i = 0; i < n; i++) begin
            cnt = 0;
            do begin
                @(posedge clock);
                cnt++;
            end while (!((use_ref ? ref_pulse : div_pulse) === 1'b1)
                       && cnt < 20000);
            check(cnt < 20000, "pulse never came");
        end
        @(negedge clock);
    endtask

    task automatic t_reset;
        repeat (20) @(posedge clock);
        check(div_pulse === 1'b0, "reset div pulse");
        check(ref_pulse === 1'b0, "reset ref pulse");
        check(unlock === 1'b1, "reset lock flag");
        reset <= 1'b0;
    endtask

    task automatic t_ref;
        wait_ev(1'b1, 3);
        check(ref_last === 16'h0190, "reference ratio wrong");
    endtask

    task automatic t_ratio(input logic rx, input logic [6:0] ch,
                           input logic [1:0] st);
        int m;
        m = (rx ? 230 : 200) + ((ch > 7'h63) ? 99 : int'(ch));
        @(posedge clock);
        freq_sel <= '{rx_mode: rx, chan: ch, step: st};
        wait_ev(1'b0, 3);
        check(div_last === 16'((4 * m + st) * 4), "ratio wrong");
    endtask

    task automatic t_lock;
        @(posedge clock);
        ref_half <= 8'h10;
        t_ratio(1'b0, 7'h00, 2'h0);
        wait_ev(1'b1, 3);
        @(posedge clock);
        @(negedge clock);
        check(unlock === 1'b0, "no lock at matched rate");
    endtask

    initial begin
        #(40 * 100000);
        check(1'b0, "watchdog expired");
        close_out();
    end

    initial begin
        t_reset();
        t_ref();
        t_ratio(1'b0, 7'h00, 2'h0);
        t_ratio(1'b0, 7'h00, 2'h3);
        t_ratio(1'b0, 7'h63, 2'h1);
        t_ratio(1'b1, 7'h00, 2'h2);
        t_ratio(1'b1, 7'h7f, 2'h0);
        t_lock();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
